// >>> verilog/olsc_top.sv
//
// Operation
// [R1] Forward limit high blocks forward rotation
// [R2] Reverse limit high blocks reverse rotation
// [R3] Opposite direction stays allowed, also coasting
// [R4] Position error held until clear input
// [R5] Forward limit from pin, or ignored
// [R6] Reverse limit from pin, or ignored
// [R7] Limit selection holds in every mode
// [R8] Parameters take effect at next power-up
// [R9] Codes 00/01: dynamic brake then coast
// [R10] Code 02: coast to stop, stay coasting
// [R11] Decel by stop torque, clamp or coast
// [R12] Torque control ignores deceleration digit
// [R13] Torque control ends in coast mode
// [R14] Zero clamp holds position reference zero
// [R15] Stop torque 0..800 percent, immediate
// [R16] Applied stop torque limited by rating
// [R17] Vertical axis should use decel with clamp
// [R18] Reverse rotation mode swaps limit directions
// [R19] Limit inputs pass two-stage synchroniser
module olsc_top
	import olsc_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock, reset, enable
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              ce,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Limit switches, high means overtravel
	input  wire logic              forward_limit_input,
	input  wire logic              reverse_limit_input,
	// Servo core status
	input  wire logic [1:0]        control_mode,
	input  wire logic              motor_turning_ccw,
	input  wire logic              motor_turning_cw,
	input  wire logic              motor_stopped,
	input  wire logic [15:0]       motor_max_torque,
	input  wire logic              position_error_clear,
	input  wire logic              power_up_load,
	// Power stage commands
	output logic                   ccw_run_allowed,
	output logic                   cw_run_allowed,
	output logic                   dynamic_brake_on,
	output logic                   power_off,
	output logic                   decel_active,
	output logic [15:0]            decel_torque_limit,
	output logic                   zero_clamp_active,
	output logic                   position_error_hold,
	// Interrupt
	output logic                   irq
);

	typedef enum logic [2:0]
	{
		ST_RUN,
		ST_BRAKE,
		ST_COAST_STOP,
		ST_DECEL,
		ST_HOLD_COAST,
		ST_HOLD_CLAMP
	} olsc_state_t;

	// Pick one hex digit out of a parameter
	function automatic logic [3:0] digit(input logic [15:0] v, input int lsb);
		logic [15:0] t;
		t = v >> lsb;
		return t[3:0];
	endfunction : digit

	// Byte-lane merge of a write into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0])
			r[7:0] = d[7:0];
		if (s[1])
			r[15:8] = d[15:8];
		return r;
	endfunction : merge16

	logic              fwd_s1_reg;
	logic              fwd_s2_reg;
	logic              rev_s1_reg;
	logic              rev_s2_reg;
	olsc_cfg_t         cfg_soft_reg;
	olsc_cfg_t         cfg_act_reg;
	logic              load_pend_reg;
	logic [15:0]       estop_reg;
	logic [IRQ_W-1:0]  irq_stat_reg;
	logic [IRQ_W-1:0]  irq_mask_reg;
	logic [IRQ_W-1:0]  irq_stat_next;
	logic [IRQ_W-1:0]  irq_clr;
	logic [IRQ_W-1:0]  irq_evt;
	olsc_state_t       state_reg;
	olsc_state_t       state_next;
	logic              aw_hold_reg;
	logic              w_hold_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              wr_go;
	logic [7:0]        wr_ofs;
	logic [7:0]        rd_ofs;
	logic [31:0]       rd_val;
	logic              rd_ok;
	logic              fwd_ot;
	logic              rev_ot;
	logic              ccw_blk;
	logic              cw_blk;
	logic              trip;
	logic              use_decel;
	logic              use_db;
	logic              stopping;

	// Two-stage synchronisers; only stage two is looked at
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			fwd_s1_reg <= 1'b0;
			fwd_s2_reg <= 1'b0;
			rev_s1_reg <= 1'b0;
			rev_s2_reg <= 1'b0;
		end
		else if (ce)
		begin
			fwd_s1_reg <= forward_limit_input;  // R19
			fwd_s2_reg <= fwd_s1_reg;           // R19
			rev_s1_reg <= reverse_limit_input;  // R19
			rev_s2_reg <= rev_s1_reg;           // R19
		end
	end

	// Limit evaluation; pin enable ignores control_mode on purpose
	always_comb
	begin
		fwd_ot = (digit(cfg_act_reg.fwd_cfg, DIG_FWD_LSB) != LIMIT_DISABLED)
			&& fwd_s2_reg;  // R1 R5 R7
		rev_ot = (digit(cfg_act_reg.rev_cfg, DIG_REV_LSB) != LIMIT_DISABLED)
			&& rev_s2_reg;  // R2 R6 R7
		if (digit(cfg_act_reg.rot_dir, DIG_ROT_LSB) == ROT_REVERSED)
		begin
			ccw_blk = rev_ot;  // R18
			cw_blk  = fwd_ot;  // R18
		end
		else
		begin
			ccw_blk = fwd_ot;
			cw_blk  = rev_ot;
		end
		trip = (ccw_blk && motor_turning_ccw) || (cw_blk && motor_turning_cw);
		use_decel = (control_mode != CTRL_TORQUE)
			&& ((digit(cfg_act_reg.stop_method, DIG_DECEL_LSB) == DECEL_CLAMP)
			|| (digit(cfg_act_reg.stop_method, DIG_DECEL_LSB) == DECEL_COAST));  // R11 R12
		use_db = digit(cfg_act_reg.stop_method, DIG_STOP_LSB) != STOP_COAST;  // R9 R10
	end

	// Stop sequence
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN:
			begin
				if (trip && use_decel)
					state_next = ST_DECEL;  // R11
				else if (trip && use_db)
					state_next = ST_BRAKE;  // R9
				else if (trip)
					state_next = ST_COAST_STOP;  // R10
			end
			ST_BRAKE, ST_COAST_STOP:
			begin
				if (motor_stopped)
					state_next = ST_HOLD_COAST;  // R9 R10 R13
			end
			ST_DECEL:
			begin
				if (motor_stopped && control_mode != CTRL_TORQUE
					&& digit(cfg_act_reg.stop_method, DIG_DECEL_LSB) == DECEL_CLAMP)
					state_next = ST_HOLD_CLAMP;  // R11
				else if (motor_stopped)
					state_next = ST_HOLD_COAST;  // R11 R13
			end
			ST_HOLD_COAST, ST_HOLD_CLAMP:
			begin
				if (!ccw_blk && !cw_blk)
					state_next = ST_RUN;
			end
			default:
				state_next = ST_RUN;
		endcase
	end

	assign stopping = (state_reg == ST_RUN) && (state_next != ST_RUN);

	// State and registered power stage commands
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_reg          <= ST_RUN;
			ccw_run_allowed    <= 1'b1;
			cw_run_allowed     <= 1'b1;
			dynamic_brake_on   <= 1'b0;
			power_off          <= 1'b0;
			decel_active       <= 1'b0;
			decel_torque_limit <= 16'h0000;
			zero_clamp_active  <= 1'b0;
		end
		else if (ce)
		begin
			state_reg        <= state_next;
			// Allowance follows the limits only, so the opposite way is free in any state
			ccw_run_allowed  <= !ccw_blk;  // R1 R2 R3
			cw_run_allowed   <= !cw_blk;   // R1 R2 R3
			dynamic_brake_on <= state_next == ST_BRAKE;  // R9
			power_off        <= state_next == ST_BRAKE || state_next == ST_COAST_STOP
				|| state_next == ST_HOLD_COAST;  // R10 R13
			decel_active     <= state_next == ST_DECEL;  // R11
			// The rating caps the setting, a lower setting wins
			decel_torque_limit <= (estop_reg > motor_max_torque) ?
				motor_max_torque : estop_reg;  // R15 R16
			zero_clamp_active <= state_next == ST_HOLD_CLAMP;  // R14
		end
	end

	// Error count hold; a new stop beats a clear in the same cycle
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			position_error_hold <= 1'b0;
		else if (ce)
		begin
			if (stopping && control_mode == CTRL_POSITION)
				position_error_hold <= 1'b1;  // R4
			else if (position_error_clear)
				position_error_hold <= 1'b0;  // R4
		end
	end

	// Active parameter set copied only at a power-up
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			load_pend_reg <= 1'b1;
			cfg_act_reg   <= '{RST_STOP_METHOD, RST_FWD_CFG, RST_REV_CFG, RST_ROT_DIR};
		end
		else if (ce)
		begin
			load_pend_reg <= 1'b0;
			if (load_pend_reg || power_up_load)
				cfg_act_reg <= cfg_soft_reg;  // R8
		end
	end

	// Write channel acceptance, address and data in either order
	assign wr_go  = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wr_ofs = 8'(awaddr_reg);

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			awaddr_reg    <= '0;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_hold_reg   <= 1'b0;
				w_hold_reg    <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready  <= 1'b0;
				s_axi_bvalid  <= 1'b1;
				s_axi_bresp   <= (wr_ofs <= OFS_IRQ_MASK && wr_ofs[1:0] == 2'b00
					&& wr_ofs != OFS_STATE) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Software parameter registers; stop torque acts at once
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cfg_soft_reg <= '{RST_STOP_METHOD, RST_FWD_CFG, RST_REV_CFG, RST_ROT_DIR};
			estop_reg    <= RST_ESTOP_TORQ;
			irq_mask_reg <= '0;
		end
		else if (ce && wr_go)
		begin
			case (wr_ofs)
				OFS_STOP_METHOD:
					cfg_soft_reg.stop_method <= merge16(cfg_soft_reg.stop_method,
						wdata_reg, wstrb_reg);
				OFS_FWD_CFG:
					cfg_soft_reg.fwd_cfg <= merge16(cfg_soft_reg.fwd_cfg, wdata_reg, wstrb_reg);
				OFS_REV_CFG:
					cfg_soft_reg.rev_cfg <= merge16(cfg_soft_reg.rev_cfg, wdata_reg, wstrb_reg);
				OFS_ROT_DIR:
					cfg_soft_reg.rot_dir <= merge16(cfg_soft_reg.rot_dir, wdata_reg, wstrb_reg);
				OFS_ESTOP_TORQ:
					// Out-of-range settings saturate rather than wrap
					estop_reg <= (merge16(estop_reg, wdata_reg, wstrb_reg) > ESTOP_TORQ_MAX) ?
						ESTOP_TORQ_MAX : merge16(estop_reg, wdata_reg, wstrb_reg);  // R15
				OFS_IRQ_MASK:
					if (wstrb_reg[0])
						irq_mask_reg <= wdata_reg[IRQ_W-1:0];
				default:
					irq_mask_reg <= irq_mask_reg;
			endcase
		end
	end

	// Sticky events, write one to clear, a new event wins
	always_comb
	begin
		irq_evt = '0;
		irq_evt[IRQ_FWD_OT]    = stopping && (fwd_ot && (ccw_blk ? motor_turning_ccw
			: motor_turning_cw));
		irq_evt[IRQ_REV_OT]    = stopping && (rev_ot && (cw_blk && !fwd_ot ? motor_turning_cw
			: (ccw_blk && !fwd_ot ? motor_turning_ccw : rev_ot && !fwd_ot)));
		irq_evt[IRQ_STOP_DONE] = (state_next == ST_HOLD_COAST || state_next == ST_HOLD_CLAMP)
			&& state_reg != ST_HOLD_COAST && state_reg != ST_HOLD_CLAMP;
		irq_clr = (wr_go && wr_ofs == OFS_IRQ_STATUS && wstrb_reg[0]) ?
			wdata_reg[IRQ_W-1:0] : '0;
		irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			irq_stat_reg <= '0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			irq_stat_reg <= irq_stat_next;
			irq <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// Read decode
	assign rd_ofs = 8'(s_axi_araddr);

	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		case (rd_ofs)
			OFS_STOP_METHOD: rd_val[15:0] = cfg_soft_reg.stop_method;
			OFS_FWD_CFG:     rd_val[15:0] = cfg_soft_reg.fwd_cfg;
			OFS_REV_CFG:     rd_val[15:0] = cfg_soft_reg.rev_cfg;
			OFS_ESTOP_TORQ:  rd_val[15:0] = estop_reg;
			OFS_ROT_DIR:     rd_val[15:0] = cfg_soft_reg.rot_dir;
			OFS_STATE:
				rd_val[7:0] = {position_error_hold, zero_clamp_active, decel_active,
					dynamic_brake_on, power_off, cw_blk, ccw_blk, state_reg != ST_RUN};
			OFS_IRQ_STATUS:  rd_val[IRQ_W-1:0] = irq_stat_reg;
			OFS_IRQ_MASK:    rd_val[IRQ_W-1:0] = irq_mask_reg;
			default:         rd_ok = 1'b0;
		endcase
	end

	// Read channel, one read in flight
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule : olsc_top

// >>> verilog/olsc_pkg.sv
package olsc_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_STOP_METHOD = 8'h00;
	localparam logic [7:0] OFS_FWD_CFG     = 8'h04;
	localparam logic [7:0] OFS_REV_CFG     = 8'h08;
	localparam logic [7:0] OFS_ESTOP_TORQ  = 8'h0C;
	localparam logic [7:0] OFS_ROT_DIR     = 8'h10;
	localparam logic [7:0] OFS_STATE       = 8'h14;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h1C;

	// Digit positions inside the 16-bit parameters
	localparam int DIG_FWD_LSB  = 12;
	localparam int DIG_REV_LSB  = 0;
	localparam int DIG_STOP_LSB = 0;
	localparam int DIG_DECEL_LSB = 4;
	localparam int DIG_ROT_LSB  = 0;

	// Digit codes
	localparam logic [3:0] FWD_FROM_PIN   = 4'h2;
	localparam logic [3:0] REV_FROM_PIN   = 4'h3;
	localparam logic [3:0] LIMIT_DISABLED = 4'h8;
	localparam logic [3:0] STOP_DB_A      = 4'h0;
	localparam logic [3:0] STOP_DB_B      = 4'h1;
	localparam logic [3:0] STOP_COAST     = 4'h2;
	localparam logic [3:0] DECEL_CLAMP    = 4'h1;
	localparam logic [3:0] DECEL_COAST    = 4'h2;
	localparam logic [3:0] ROT_REVERSED   = 4'h1;

	// Reset values and stop torque ceiling
	localparam logic [15:0] RST_STOP_METHOD = 16'h0000;
	localparam logic [15:0] RST_FWD_CFG     = 16'h2000;
	localparam logic [15:0] RST_REV_CFG     = 16'h0003;
	localparam logic [15:0] RST_ESTOP_TORQ  = 16'h0320;
	localparam logic [15:0] ESTOP_TORQ_MAX  = 16'h0320;
	localparam logic [15:0] RST_ROT_DIR     = 16'h0000;

	// Interrupt status bit positions
	localparam int IRQ_FWD_OT    = 0;
	localparam int IRQ_REV_OT    = 1;
	localparam int IRQ_STOP_DONE = 2;
	localparam int IRQ_W         = 3;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Control method as driven by the servo core
	typedef enum logic [1:0]
	{
		CTRL_SPEED,
		CTRL_POSITION,
		CTRL_TORQUE
	} olsc_ctrl_t;

	// Parameter set latched at power-up
	typedef struct packed
	{
		logic [15:0] stop_method;
		logic [15:0] fwd_cfg;
		logic [15:0] rev_cfg;
		logic [15:0] rot_dir;
	} olsc_cfg_t;

endpackage : olsc_pkg

// >>> tb/olsc_top_asserts.sv
module olsc_chk
	import olsc_pkg::*;
(
	// Clock, reset, enable
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        ce,
	// Limit and servo core inputs
	input wire logic        forward_limit_input,
	input wire logic        reverse_limit_input,
	input wire logic [1:0]  control_mode,
	input wire logic        motor_stopped,
	input wire logic [15:0] motor_max_torque,
	input wire logic        position_error_clear,
	// Power stage commands
	input wire logic        ccw_run_allowed,
	input wire logic        cw_run_allowed,
	input wire logic        dynamic_brake_on,
	input wire logic        power_off,
	input wire logic        decel_active,
	input wire logic [15:0] decel_torque_limit,
	input wire logic        zero_clamp_active,
	input wire logic        position_error_hold
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// Four quiet samples cover the two-flop synchroniser with margin
	AST_BOTH_FREE: assert property (
		(ce && !forward_limit_input && !reverse_limit_input) [*4] |=>
		ccw_run_allowed && cw_run_allowed) else $error("free limits still block");
	AST_ONE_SIDE: assert property (
		(ce && !reverse_limit_input) [*4] |=> ccw_run_allowed || cw_run_allowed)
		else $error("both directions blocked");
	AST_DB_COAST: assert property (
		dynamic_brake_on |-> power_off) else $error("brake without power off");
	AST_BRAKE_END: assert property (
		$fell(dynamic_brake_on) |-> $past(motor_stopped)) else $error("brake ended early");
	AST_DECEL_END: assert property (
		$fell(decel_active) |-> $past(motor_stopped)) else $error("decel ended early");
	AST_CLAMP_POWERED: assert property (
		zero_clamp_active |-> !power_off && !dynamic_brake_on && !decel_active)
		else $error("clamp while unpowered");
	AST_TORQ_NO_DECEL: assert property (
		$rose(decel_active) |-> $past(control_mode) != CTRL_TORQUE)
		else $error("decel in torque mode");
	AST_TORQ_NO_CLAMP: assert property (
		$rose(zero_clamp_active) |-> $past(control_mode) != CTRL_TORQUE)
		else $error("clamp in torque mode");
	AST_ERR_KEEP: assert property (
		ce && position_error_hold && !position_error_clear |=> position_error_hold)
		else $error("error dropped without clear");
	AST_ERR_POS: assert property (
		$rose(position_error_hold) |-> $past(control_mode) == CTRL_POSITION)
		else $error("error hold outside position mode");
	AST_TORQ_CAP: assert property (
		decel_torque_limit <= ESTOP_TORQ_MAX) else $error("stop torque above cap");
	// Compare against the rating the drive saw when it latched the limit
	AST_TORQ_RATING: assert property (
		ce |=> decel_torque_limit <= $past(motor_max_torque))
		else $error("stop torque above rating");
endmodule : olsc_chk

bind olsc_top olsc_chk u_chk (.clock, .rst, .ce, .forward_limit_input, .reverse_limit_input,
	.control_mode, .motor_stopped, .motor_max_torque, .position_error_clear,
	.ccw_run_allowed, .cw_run_allowed, .dynamic_brake_on, .power_off, .decel_active,
	.decel_torque_limit, .zero_clamp_active, .position_error_hold);

// >>> tb/olsc_motor_model.sv
module olsc_motor_model
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Bench commands
	input  wire logic       run_ccw,
	input  wire logic       run_cw,
	input  wire logic       fwd_sw,
	input  wire logic       rev_sw,
	input  wire logic [7:0] stop_delay,
	// Commands from the drive
	input  wire logic       ccw_run_allowed,
	input  wire logic       cw_run_allowed,
	input  wire logic       dynamic_brake_on,
	input  wire logic       power_off,
	input  wire logic       decel_active,
	// Switch and shaft state
	output logic            forward_limit_input,
	output logic            reverse_limit_input,
	output logic            motor_turning_ccw,
	output logic            motor_turning_cw,
	output logic            motor_stopped
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] stop_cnt_reg;
	logic       ccw_reg;
	logic       cw_reg;

	// Switches are wired straight through, a tripped switch reads high
	assign forward_limit_input = fwd_sw;
	assign reverse_limit_input = rev_sw;
	assign motor_turning_ccw   = ccw_reg;
	assign motor_turning_cw    = cw_reg;
	assign motor_stopped       = !(ccw_reg || cw_reg);

	// Shaft spins down over stop_delay cycles, so slow and prompt stops both occur
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			stop_cnt_reg <= 8'h00;
			ccw_reg      <= 1'b0;
			cw_reg       <= 1'b0;
		end
		else if (dynamic_brake_on || power_off || decel_active)
		begin
			stop_cnt_reg <= stop_cnt_reg + 8'h01;
			if (stop_cnt_reg >= stop_delay)
			begin
				ccw_reg <= 1'b0;
				cw_reg  <= 1'b0;
			end
		end
		else
		begin
			stop_cnt_reg <= 8'h00;
			ccw_reg      <= run_ccw && ccw_run_allowed;
			cw_reg       <= run_cw && cw_run_allowed;
		end
	end
endmodule : olsc_motor_model

// >>> tb/tb_overtravel_limit_stop_control.sv
module tb_overtravel_limit_stop_control
	import olsc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, stop_delay = 8'h10, blk;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, cw, irq_on;
	logic [1:0]  s_axi_bresp, s_axi_rresp, control_mode = 2'h0;
	logic [15:0] motor_max_torque = 16'h0320, decel_torque_limit, torq, torq_cap;
	logic        position_error_clear = 1'b0, power_up_load = 1'b0, run_ccw = 1'b0;
	logic        run_cw = 1'b0, fwd_sw = 1'b0, rev_sw = 1'b0, forward_limit_input;
	logic        reverse_limit_input, motor_turning_ccw, motor_turning_cw, motor_stopped;
	logic        ccw_run_allowed, cw_run_allowed, dynamic_brake_on, power_off;
	logic        decel_active, zero_clamp_active, position_error_hold, irq;
	logic [34:0] notes[$], exp_note;
	logic [35:0] rw;
	int          err_total = 0, checks = 0;
	// Rows: mode, reversed rotation, reverse switch, stop code, stopping bits, hold bits
	localparam logic [35:0] ROWS [8] = '{
		{2'h0, 1'b0, 1'b0, 16'h0000, 8'h18, 8'h08},
		{2'h0, 1'b0, 1'b1, 16'h0001, 8'h18, 8'h08},
		{2'h0, 1'b0, 1'b0, 16'h0002, 8'h08, 8'h08},
		{2'h0, 1'b0, 1'b0, 16'h0010, 8'h20, 8'h40},
		{2'h0, 1'b1, 1'b0, 16'h0020, 8'h20, 8'h08},
		{2'h2, 1'b0, 1'b0, 16'h0010, 8'h18, 8'h08},
		{2'h2, 1'b1, 1'b1, 16'h0012, 8'h08, 8'h08},
		{2'h1, 1'b0, 1'b0, 16'h0010, 8'ha0, 8'hc0}};

	olsc_top dut (.clock, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .forward_limit_input,
		.reverse_limit_input, .control_mode, .motor_turning_ccw, .motor_turning_cw,
		.motor_stopped, .motor_max_torque, .position_error_clear, .power_up_load,
		.ccw_run_allowed, .cw_run_allowed, .dynamic_brake_on, .power_off, .decel_active,
		.decel_torque_limit, .zero_clamp_active, .position_error_hold, .irq);
	olsc_motor_model u_motor (.clock, .rst, .run_ccw, .run_cw, .fwd_sw, .rev_sw,
		.stop_delay, .ccw_run_allowed, .cw_run_allowed, .dynamic_brake_on, .power_off,
		.decel_active, .forward_limit_input, .reverse_limit_input, .motor_turning_ccw,
		.motor_turning_cw, .motor_stopped);

	// Free-running bench clock
	always #25 clock = ~clock;

	task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	// One bus transfer; each channel is dropped at the edge that takes it
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [34:0] e);
		logic [2:0] tk;
		logic       done;
		notes.push_back(e);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		done = 1'b0;
		while (!done)
		begin
			@(negedge clock);
			tk = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready,
				s_axi_arvalid && s_axi_arready};
			done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
			@(posedge clock);
			s_axi_awvalid <= s_axi_awvalid && !tk[2];
			s_axi_wvalid <= s_axi_wvalid && !tk[1];
			s_axi_arvalid <= s_axi_arvalid && !tk[0];
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		bus(1'b1, a, d, {1'b0, r, 32'h0000_0000});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic q = 1'b0,
		input logic [1:0] r = RESP_OKAY);
		bus(1'b0, a, 32'h0000_0000, {q, r, e});
	endtask : rd

	task automatic load();
		@(posedge clock);
		power_up_load <= 1'b1;
		@(posedge clock);
		power_up_load <= 1'b0;
	endtask : load

	// Bounded wait for a stop to begin or for the shaft to stand still
	task automatic wait_on(input logic ph);
		logic hit;
		hit = 1'b0;
		for (int n = 0; n < 300 && !hit; n++)
		begin
			@(negedge clock);
			hit = ph ? (power_off || decel_active) : motor_stopped;
		end
		// Running out of patience is a failure in its own right
		if (!hit)
			err_total++;
		@(posedge clock);
	endtask : wait_on

	// Results are settled at the falling edge before their handshake edge
	always @(negedge clock)
		if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready))
		begin
			exp_note = (notes.size() > 0) ? notes.pop_front() : '1;
			chk(s_axi_bvalid ? {1'b0, s_axi_bresp, 32'h0000_0000}
				: {irq, s_axi_rresp, s_axi_rdata}, exp_note);
		end

	// Watchdog, well beyond the expected run length
	initial
	begin
		repeat (40000) @(posedge clock);
		err_total++;
		test_done();
	end

	// Main sequence
	initial
	begin
		void'($urandom(32'h33d6_c71d));
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		rd(OFS_STOP_METHOD, {16'h0000, RST_STOP_METHOD});
		rd(OFS_FWD_CFG, {16'h0000, RST_FWD_CFG});
		rd(OFS_REV_CFG, {16'h0000, RST_REV_CFG});
		rd(OFS_ESTOP_TORQ, 32'h0000_0320);
		rd(8'h20, 32'h0000_0000, 1'b0, RESP_SLVERR);
		wr(OFS_STATE, 32'h0000_00ff, RESP_SLVERR);
		torq = 16'($urandom % 801);
		wr(OFS_ESTOP_TORQ, {16'h0000, torq});
		rd(OFS_ESTOP_TORQ, {16'h0000, torq});
		wr(OFS_ESTOP_TORQ, 32'h0000_0fff);
		rd(OFS_ESTOP_TORQ, 32'h0000_0320);
		wr(OFS_ESTOP_TORQ, {16'h0000, torq});
		// Disabled limit applies only after the next power-up, checked in speed and in torque mode
		for (int j = 0; j < 2; j++)
		begin
			wr(j ? OFS_REV_CFG : OFS_FWD_CFG, j ? 32'h0000_0008 : 32'h0000_8000);
			control_mode <= j ? CTRL_TORQUE : CTRL_SPEED;
			fwd_sw <= !j;
			rev_sw <= j;
			repeat (5) @(posedge clock);
			rd(OFS_STATE, j ? 32'h0000_0004 : 32'h0000_0002);
			load();
			repeat (5) @(posedge clock);
			rd(OFS_STATE, 32'h0000_0000);
			fwd_sw <= 1'b0;
			rev_sw <= 1'b0;
			wr(j ? OFS_REV_CFG : OFS_FWD_CFG, j ? 32'h0000_0003 : 32'h0000_2000);
			load();
		end
		// Trip into a limit while moving, once per row of ROWS, eight stop method and mode pairs
		for (int i = 0; i < 8; i++)
		begin
			rw = ROWS[i];
			irq_on = (i % 2 == 0);
			cw = rw[32] ^ rw[33];
			blk = cw ? 8'h05 : 8'h03;
			control_mode <= rw[35:34];
			wr(OFS_IRQ_MASK, irq_on ? 32'h0000_0007 : 32'h0000_0000);
			wr(OFS_STOP_METHOD, {16'h0000, rw[31:16]});
			wr(OFS_ROT_DIR, {31'h0000_0000, rw[33]});
			load();
			stop_delay <= 8'(12 + $urandom % 30);
			motor_max_torque <= 16'($urandom % 801);
			run_cw <= cw;
			run_ccw <= !cw;
			repeat (6) @(posedge clock);
			fwd_sw <= !rw[32];
			rev_sw <= rw[32];
			wait_on(1'b1);
			run_cw <= 1'b0;
			run_ccw <= 1'b0;
			if (rw[15:8] != 8'h00)
				rd(OFS_STATE, {24'h00_0000, rw[15:8] | blk}, irq_on);
			wait_on(1'b0);
			repeat (3) @(posedge clock);
			// Look between edges, where the registered commands are settled
			@(negedge clock);
			torq_cap = (torq > motor_max_torque) ? motor_max_torque : torq;
			chk({33'h0_0000_0000, ccw_run_allowed, cw_run_allowed}, {33'h0_0000_0000, cw, !cw});
			chk({19'h0_0000, decel_torque_limit}, {19'h0_0000, torq_cap});
			rd(OFS_STATE, {24'h00_0000, rw[7:0] | blk}, irq_on);
			rd(OFS_IRQ_STATUS, {29'h0000_0000, 1'b1, rw[32], !rw[32]}, irq_on);
			position_error_clear <= 1'b1;
			fwd_sw <= 1'b0;
			rev_sw <= 1'b0;
			@(posedge clock);
			position_error_clear <= 1'b0;
			repeat (6) @(posedge clock);
			rd(OFS_STATE, 32'h0000_0000, irq_on);
			wr(OFS_IRQ_STATUS, 32'h0000_0007);
			rd(OFS_IRQ_STATUS, 32'h0000_0000);
		end
		test_done();
	end
endmodule : tb_overtravel_limit_stop_control
